// ==== src/cgrsc_pkg.sv ====
package cgrsc_pkg;

    localparam int AXI_AW = 8;

    // Register byte offsets.
    localparam logic [AXI_AW-1:0] OFS_CAUSE_WDT = 8'h00;
    localparam logic [AXI_AW-1:0] OFS_STANDBY = 8'h04;
    localparam logic [AXI_AW-1:0] OFS_DMA_HOLD = 8'h08;
    localparam logic [AXI_AW-1:0] OFS_TB_CLEAR = 8'h0C;
    localparam logic [AXI_AW-1:0] OFS_GEAR = 8'h10;
    localparam logic [AXI_AW-1:0] OFS_WD_SERVICE = 8'h14;

    // Field positions.
    localparam int POS_POWERON = 15;
    localparam int POS_WATCHDOG_CAUSE_FLAG = 13;
    localparam int POS_PINRST = 12;
    localparam int POS_SWRST = 11;
    localparam int POS_WDT_CYCLE = 8;
    localparam int POS_STOP = 7;
    localparam int POS_SLEEP = 6;
    localparam int POS_FLOAT = 5;
    localparam int POS_SWRST_BIT = 4;
    localparam int POS_STAB = 2;
    localparam int POS_DMA_HOLD = 8;
    localparam int POS_GEAR = 14;
    localparam int POS_DOUBLER = 13;
    localparam int POS_SRC = 8;

    // Values after reset.
    localparam logic [1:0] RST_WDT_CYCLE = 2'h0;
    localparam logic [1:0] RST_STAB = 2'h3;
    localparam logic [1:0] RST_GEAR = 2'h3;
    localparam logic RST_SRC = 1'b1;
    localparam logic RST_DOUBLER = 1'b0;
    localparam logic [3:0] RST_DMA_HOLD = 4'h0;

    // Two-byte keys.
    localparam logic [7:0] KEY_FIRST = 8'hA5;
    localparam logic [7:0] KEY_SECOND = 8'h5A;

    // Timing: exponents of the base period and timebase width.
    localparam int WD_EXP_DEFAULT = 15;
    localparam int STAB_EXP_DEFAULT = 15;
    localparam int TB_W = 23;
    localparam int RESET_HOLD_DEFAULT = 16;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_SLEEP = 4'h2,
        ST_STOP = 4'h4,
        ST_WAIT = 4'h8
    } cgrsc_state_t;

    // Reset cause bits: [3] power-on, [2] watchdog, [1] pin, [0] software.
    typedef struct packed {
        logic [3:0] cause;
        logic [1:0] wdt_cycle;
        logic float_on_stop;
        logic [1:0] stab_sel;
        logic [3:0] dma_hold;
        logic [1:0] gear;
        logic src;
        logic [1:0] gear_act;
        logic src_act;
        logic tb_armed;
        logic wd_armed;
        logic [TB_W-1:0] tb;
        logic wd_ff;
        logic osc_half;
        logic [2:0] gear_cnt;
        cgrsc_state_t state;
        logic [7:0] rst_cnt;
        logic cpu_en;
        logic per_en;
        logic osc_run;
        logic pin_float;
        logic dma_out;
        logic int_rst_n;
        logic aw_got;
        logic [AXI_AW-1:0] aw_addr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } cgrsc_st_t;

endpackage

// ==== src/cgrsc_top.sv ====
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps

module cgrsc_top #(
    parameter int WD_BASE_EXP = cgrsc_pkg::WD_EXP_DEFAULT,
    parameter int STAB_BASE_EXP = cgrsc_pkg::STAB_EXP_DEFAULT,
    parameter int RESET_HOLD = cgrsc_pkg::RESET_HOLD_DEFAULT
) (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic PIN_RESET_N,
    input wire logic OSC_TICK,
    input wire logic PLL_TICK,
    input wire logic WAKE_IRQ,
    input wire logic BUS_HOLD,
    input wire logic DMA_REQ_IN,
    output logic CPU_CLK_EN,
    output logic PERIPH_CLK_EN,
    output logic OSC_RUN,
    output logic PIN_FLOAT,
    output logic DMA_REQ_OUT,
    output logic INT_RESET_N,
    input wire logic [cgrsc_pkg::AXI_AW-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [cgrsc_pkg::AXI_AW-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    import cgrsc_pkg::*;

    // The largest exponent used is BASE + 6, and the timebase must hold it.
    if (WD_BASE_EXP < 1 || WD_BASE_EXP + 7 > TB_W || STAB_BASE_EXP < 1 || STAB_BASE_EXP + 7 > TB_W) begin : g_bad_exp
        $error("Timebase exponents out of range.");
    end
    if (RESET_HOLD < 1 || RESET_HOLD > 255) begin : g_bad_hold
        $error("RESET_HOLD must be 1 to 255.");
    end

    localparam logic [7:0] HOLD_CNT = 8'(RESET_HOLD);

    cgrsc_st_t s;
    cgrsc_st_t n;

    logic osc_live;
    logic base;
    logic [2:0] gmask;
    logic boundary;
    logic [TB_W-1:0] wd_mask;
    logic wd_carry;
    logic stab_bit;
    logic wd_fire;
    logic sw_req;
    logic pin_rst;
    logic do_write;
    logic tb_clear;
    logic wd_service;
    logic wr_hit;
    logic rd_hit;
    logic [15:0] rd_word;
    logic [7:0] wb0;
    logic [7:0] wb1;

    function automatic logic [15:0] read_reg(input cgrsc_st_t st, input logic [AXI_AW-1:0] a, output logic hit);
        logic [15:0] v;
        v = 16'h0000;
        hit = 1'b1;
        case (a)
            OFS_CAUSE_WDT: begin
                v[POS_POWERON] = st.cause[3];
                v[POS_WATCHDOG_CAUSE_FLAG] = st.cause[2];
                v[POS_PINRST] = st.cause[1];
                v[POS_SWRST] = st.cause[0];
                v[POS_WDT_CYCLE +: 2] = st.wdt_cycle;
            end
            OFS_STANDBY: begin
                v[POS_FLOAT] = st.float_on_stop;
                v[POS_SWRST_BIT] = 1'b1;
                v[POS_STAB +: 2] = st.stab_sel;
            end
            OFS_DMA_HOLD: begin
                v[POS_DMA_HOLD +: 4] = st.dma_hold;
            end
            OFS_GEAR: begin
                v[POS_GEAR +: 2] = st.gear;
                v[POS_DOUBLER] = RST_DOUBLER;
                v[POS_SRC] = st.src;
            end
            // Key registers read as zero; software gets nothing from them.
            OFS_TB_CLEAR: v = 16'h0000;
            OFS_WD_SERVICE: v = 16'h0000;
            default: hit = 1'b0;
        endcase
        return v;
    endfunction

    always_comb begin
        n = s;
        rd_word = 16'h0000;
        rd_hit = 1'b0;
        pin_rst = ~PIN_RESET_N;
        sw_req = 1'b0;
        tb_clear = 1'b0;
        wd_service = 1'b0;
        wd_fire = 1'b0;
        wr_hit = 1'b0;
        wb0 = s.wdata[7:0];
        wb1 = s.wdata[15:8];

        // Oscillator and PLL are both halted in stop, so no base tick arrives then.
        osc_live = (s.state != ST_STOP);
        if (OSC_TICK && osc_live) begin
            n.osc_half = ~s.osc_half;
        end
        base = osc_live && (s.src_act ? (OSC_TICK && s.osc_half) : PLL_TICK);

        case (s.gear_act)
            2'h0: gmask = 3'h0;
            2'h1: gmask = 3'h1;
            2'h2: gmask = 3'h3;
            default: gmask = 3'h7;
        endcase
        boundary = base && ((s.gear_cnt & gmask) == gmask);
        if (base) begin
            n.gear_cnt = boundary ? 3'h0 : s.gear_cnt + 3'h1;
        end
        // Loading the new ratio only at the end of a CPU period avoids a short phase.
        if (boundary) begin
            n.gear_act = s.gear;
            n.src_act = s.src;
        end

        // Timebase tap for the watchdog: one carry every 2^k base periods.
        wd_mask = ~({TB_W{1'b1}} << (WD_BASE_EXP + 2 * int'(s.wdt_cycle)));
        wd_carry = base && ((s.tb & wd_mask) == wd_mask);
        stab_bit = |(s.tb & ({{(TB_W-1){1'b0}}, 1'b1} << (STAB_BASE_EXP + 2 * int'(s.stab_sel))));
        if (base) begin
            n.tb = s.tb + {{(TB_W-1){1'b0}}, 1'b1};
        end

        // Write channel: address and data are taken in either order.
        if (S_AXI_AWVALID && s.awready) begin
            n.aw_got = 1'b1;
            n.aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && s.wready) begin
            n.w_got = 1'b1;
            n.wdata = S_AXI_WDATA;
            n.wstrb = S_AXI_WSTRB;
        end
        do_write = s.aw_got && s.w_got && !s.bvalid;
        if (do_write) begin
            wr_hit = 1'b1;
            case (s.aw_addr)
                OFS_CAUSE_WDT: begin
                    if (s.wstrb[1]) begin
                        n.wdt_cycle = wb1[POS_WDT_CYCLE-8 +: 2];
                    end
                end
                OFS_STANDBY: begin
                    if (s.wstrb[0]) begin
                        n.float_on_stop = wb0[POS_FLOAT];
                        n.stab_sel = wb0[POS_STAB +: 2];
                        if (!wb0[POS_SWRST_BIT]) begin
                            sw_req = 1'b1;
                        end else if (wb0[POS_STOP]) begin
                            n.state = ST_STOP;
                        end else if (wb0[POS_SLEEP]) begin
                            n.state = ST_SLEEP;
                        end
                    end
                end
                OFS_DMA_HOLD: begin
                    if (s.wstrb[1]) begin
                        n.dma_hold = wb1[POS_DMA_HOLD-8 +: 4];
                    end
                end
                OFS_TB_CLEAR: begin
                    if (s.wstrb[0]) begin
                        tb_clear = s.tb_armed && (wb0 == KEY_SECOND);
                        n.tb_armed = (wb0 == KEY_FIRST);
                    end
                end
                OFS_GEAR: begin
                    // The doubler status bit has no storage and so ignores writes.
                    if (s.wstrb[1]) begin
                        n.gear = wb1[POS_GEAR-8 +: 2];
                        n.src = wb1[POS_SRC-8];
                    end
                end
                OFS_WD_SERVICE: begin
                    if (s.wstrb[0]) begin
                        wd_service = s.wd_armed && (wb0 == KEY_SECOND);
                        n.wd_armed = (wb0 == KEY_FIRST);
                    end
                end
                default: wr_hit = 1'b0;
            endcase
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s.bvalid && S_AXI_BREADY) begin
            n.bvalid = 1'b0;
        end

        // Read channel: one read at a time.
        if (S_AXI_ARVALID && s.arready) begin
            rd_word = read_reg(s, S_AXI_ARADDR, rd_hit);
            n.rvalid = 1'b1;
            n.rdata = {16'h0000, rd_word};
            n.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s.rvalid && S_AXI_RREADY) begin
            n.rvalid = 1'b0;
        end

        // Clearing the timebase restarts every count taken from it.
        if (tb_clear) begin
            n.tb = '0;
        end

        // Standby sequencing.
        case (s.state)
            ST_RUN: begin
            end
            ST_SLEEP: begin
                if (WAKE_IRQ) begin
                    n.state = ST_RUN;
                end
            end
            ST_STOP: begin
                if (WAKE_IRQ) begin
                    n.state = ST_WAIT;
                    n.tb = '0;
                end
            end
            ST_WAIT: begin
                if (stab_bit) begin
                    n.state = ST_RUN;
                end
            end
            default: n.state = ST_RUN;
        endcase

        // Watchdog: first carry arms, a second unserviced carry fires.
        if (s.state != ST_RUN || BUS_HOLD) begin
            n.wd_ff = 1'b0;
        end else begin
            if (wd_service) begin
                n.wd_ff = 1'b0;
            end
            if (wd_carry) begin
                // A service landing on the carry edge still counts, so the carry only sets the flip-flop then.
                if (s.wd_ff && !wd_service) begin
                    wd_fire = 1'b1;
                end else begin
                    n.wd_ff = 1'b1;
                end
            end
        end

        // Reset generation; pin beats watchdog, watchdog beats software.
        if (pin_rst) begin
            n.cause = 4'b0010;
        end else if (wd_fire) begin
            n.cause = 4'b0100;
        end else if (sw_req) begin
            n.cause = 4'b0001;
        end
        if (pin_rst || wd_fire || sw_req) begin
            n.rst_cnt = HOLD_CNT;
        end else if (s.rst_cnt != 8'h00) begin
            n.rst_cnt = s.rst_cnt - 8'h01;
        end
        // Stabilization select survives every reset but power-on.
        if (n.rst_cnt != 8'h00) begin
            n.wdt_cycle = RST_WDT_CYCLE;
            n.float_on_stop = 1'b0;
            n.dma_hold = RST_DMA_HOLD;
            n.gear = RST_GEAR;
            n.src = RST_SRC;
            n.gear_act = RST_GEAR;
            n.src_act = RST_SRC;
            n.gear_cnt = 3'h0;
            n.tb_armed = 1'b0;
            n.wd_armed = 1'b0;
            n.tb = '0;
            n.wd_ff = 1'b0;
            n.state = ST_RUN;
        end

        n.int_rst_n = (n.rst_cnt == 8'h00);
        n.cpu_en = boundary && (s.state == ST_RUN) && (s.rst_cnt == 8'h00);
        n.per_en = base && (s.state == ST_RUN || s.state == ST_SLEEP) && (s.rst_cnt == 8'h00);
        n.osc_run = (n.state != ST_STOP);
        n.pin_float = (n.state == ST_STOP) && n.float_on_stop;
        n.dma_out = DMA_REQ_IN && (s.dma_hold == 4'h0);
        n.awready = !n.aw_got && !n.bvalid;
        n.wready = !n.w_got && !n.bvalid;
        n.arready = !n.rvalid;
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            s <= '0;
            s.cause <= 4'b1000;
            s.stab_sel <= RST_STAB;
            s.wdt_cycle <= RST_WDT_CYCLE;
            s.gear <= RST_GEAR;
            s.src <= RST_SRC;
            s.gear_act <= RST_GEAR;
            s.src_act <= RST_SRC;
            s.state <= ST_RUN;
            s.rst_cnt <= HOLD_CNT;
            s.osc_run <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign CPU_CLK_EN = s.cpu_en;
    assign PERIPH_CLK_EN = s.per_en;
    assign OSC_RUN = s.osc_run;
    assign PIN_FLOAT = s.pin_float;
    assign DMA_REQ_OUT = s.dma_out;
    assign INT_RESET_N = s.int_rst_n;
    assign S_AXI_AWREADY = s.awready;
    assign S_AXI_WREADY = s.wready;
    assign S_AXI_BRESP = s.bresp;
    assign S_AXI_BVALID = s.bvalid;
    assign S_AXI_ARREADY = s.arready;
    assign S_AXI_RDATA = s.rdata;
    assign S_AXI_RRESP = s.rresp;
    assign S_AXI_RVALID = s.rvalid;

endmodule

// ==== tb/cgrsc_far_model.sv ====
`timescale 1ns/1ps
module cgrsc_far_model #(
    parameter int OSC_DIV = 2,
    parameter int PLL_DIV = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic osc_run,
    input wire logic dma_want,
    output logic osc_tick,
    output logic pll_tick,
    output logic dma_req
);
    int oc;
    int pc;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            oc <= 0;
            pc <= 0;
            osc_tick <= 1'b0;
            pll_tick <= 1'b0;
            dma_req <= 1'b0;
        end else begin
            oc <= (oc == OSC_DIV - 1) ? 0 : oc + 1;
            pc <= (pc == PLL_DIV - 1) ? 0 : pc + 1;
            // Oscillator and PLL both halt while stopped, so no ticks reach the block then.
            osc_tick <= osc_run && oc == OSC_DIV - 1;
            pll_tick <= osc_run && pc == PLL_DIV - 1;
            dma_req <= dma_want;
        end
    end
endmodule

// ==== tb/cgrsc_top_asserts.sv ====
`timescale 1ns/1ps
module cgrsc_top_asserts #(
    parameter int WD_BASE_EXP = 15,
    parameter int STAB_BASE_EXP = 15,
    parameter int RESET_HOLD = 16
) (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic PIN_RESET_N,
    input wire logic DMA_REQ_IN,
    input wire logic CPU_CLK_EN,
    input wire logic PERIPH_CLK_EN,
    input wire logic OSC_RUN,
    input wire logic PIN_FLOAT,
    input wire logic DMA_REQ_OUT,
    input wire logic INT_RESET_N,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic S_AXI_RVALID
);
    default clocking cgrsc_cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_N);
    a_dma_needs_source: assert property (DMA_REQ_OUT |-> $past(DMA_REQ_IN))
        else $error("DMA request forwarded without a source request");
    // The first stopped cycle is excused because OSC_RUN is registered from the next state and the clock enables from the current one.
    a_stop_all_quiet: assert property (!OSC_RUN && !$past(OSC_RUN) |-> !CPU_CLK_EN && !PERIPH_CLK_EN)
        else $error("Clock pulses seen while stopped");
    a_float_only_stop: assert property (PIN_FLOAT |-> !OSC_RUN)
        else $error("Pins floated outside stop");
    a_reset_cpu_quiet: assert property (!INT_RESET_N && !$past(INT_RESET_N) |-> !CPU_CLK_EN)
        else $error("CPU clock pulse during internal reset");
    a_pin_forces_reset: assert property (!PIN_RESET_N |=> !INT_RESET_N)
        else $error("Reset pin did not assert internal reset");
    a_reset_two_cycles: assert property ($fell(INT_RESET_N) |=> !INT_RESET_N)
        else $error("Internal reset shorter than two cycles");
    a_write_answered: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
        |-> ##[1:2] S_AXI_BVALID)
        else $error("Write response missing");
    a_read_answered: assert property (S_AXI_ARVALID && S_AXI_ARREADY |-> ##[1:2] S_AXI_RVALID)
        else $error("Read response missing");
    cover property (!OSC_RUN);
    cover property (PIN_FLOAT);
    cover property ($fell(INT_RESET_N));
    cover property (S_AXI_BVALID && S_AXI_BRESP == 2'h2);
endmodule
bind cgrsc_top cgrsc_top_asserts #(.WD_BASE_EXP(WD_BASE_EXP), .STAB_BASE_EXP(STAB_BASE_EXP), .RESET_HOLD(RESET_HOLD))
    cgrsc_top_asserts_inst (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .PIN_RESET_N(PIN_RESET_N), .DMA_REQ_IN(DMA_REQ_IN),
    .CPU_CLK_EN(CPU_CLK_EN), .PERIPH_CLK_EN(PERIPH_CLK_EN), .OSC_RUN(OSC_RUN), .PIN_FLOAT(PIN_FLOAT),
    .DMA_REQ_OUT(DMA_REQ_OUT), .INT_RESET_N(INT_RESET_N), .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID));

// ==== tb/cgrsc_top_tb.sv ====
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin fail_count++; \
    $display("Error at %0t: got %0h expected %0h", $time, got, exp); end end
module cgrsc_top_tb;
    import cgrsc_pkg::*;
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic [1:0] resp;
    } cgrsc_row_t;
    logic clk_sys, rst_n, pin_reset_n, osc_tick, pll_tick, wake_irq, bus_hold, dma_req_in, dma_want;
    logic cpu_clk_en, periph_clk_en, osc_run, pin_float, dma_req_out, int_reset_n;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    int fail_count = 0;
    int compares = 0;
    int cyc = 0;
    int dips = 0;
    int n, k, a, b, d0;
    cgrsc_row_t rows [10];
    always #4 clk_sys = ~clk_sys;
    always @(negedge int_reset_n) dips++;
    cgrsc_top #(.WD_BASE_EXP(3), .STAB_BASE_EXP(1), .RESET_HOLD(2)) cgrsc_top_inst (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .PIN_RESET_N(pin_reset_n), .OSC_TICK(osc_tick), .PLL_TICK(pll_tick),
        .WAKE_IRQ(wake_irq), .BUS_HOLD(bus_hold), .DMA_REQ_IN(dma_req_in), .CPU_CLK_EN(cpu_clk_en),
        .PERIPH_CLK_EN(periph_clk_en), .OSC_RUN(osc_run), .PIN_FLOAT(pin_float), .DMA_REQ_OUT(dma_req_out),
        .INT_RESET_N(int_reset_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    cgrsc_far_model cgrsc_far_model_inst (.clk(clk_sys), .rst_n(rst_n), .osc_run(osc_run), .dma_want(dma_want),
        .osc_tick(osc_tick), .pll_tick(pll_tick), .dma_req(dma_req_in));
    task automatic results();
        if (fail_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic wr_chk(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
        awaddr <= ad;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
        `CHK(bresp, er)
        bready <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd_chk(input logic [7:0] ad, input logic [31:0] e, input logic [1:0] er);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (arready) arvalid <= 1'b0;
        end while (!(rvalid && rready));
        `CHK(rdata, e)
        `CHK(rresp, er)
        rready <= 1'b0;
        @(posedge clk_sys);
    endtask
    // A bounded wait on the internal reset (sel 0) or on a CPU clock pulse (sel 1).
    task automatic waits(input int sel, input logic v, output int c);
        c = 0;
        do begin
            @(posedge clk_sys);
            c++;
        end while ((sel ? cpu_clk_en : int_reset_n) !== v && c < 3000);
        if (c >= 3000) fail_count++;
    endtask
    task automatic period(output int p);
        waits(1, 1'b1, p);
        p = 0;
        do begin
            @(posedge clk_sys);
            p++;
        end while (cpu_clk_en !== 1'b1 && p < 100);
    endtask
    task automatic count(input int nc, output int cc, output int pc);
        cc = 0;
        pc = 0;
        repeat (nc) begin
            @(posedge clk_sys);
            cc += (cpu_clk_en === 1'b1);
            pc += (periph_clk_en === 1'b1);
        end
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            results();
        end
    end
    initial begin
        clk_sys = 1'b0;
        rst_n = 1'b0;
        pin_reset_n = 1'b1;
        wake_irq = 1'b0;
        bus_hold = 1'b1;
        dma_want = 1'b0;
        {awaddr, araddr, wdata, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        rows[0] = '{1'b0, OFS_CAUSE_WDT, 32'h0, 32'h8000, RESP_OKAY};
        rows[1] = '{1'b0, OFS_STANDBY, 32'h0, 32'h001C, RESP_OKAY};
        rows[2] = '{1'b0, OFS_GEAR, 32'h0, 32'hC100, RESP_OKAY};
        rows[3] = '{1'b0, OFS_DMA_HOLD, 32'h0, 32'h0, RESP_OKAY};
        rows[4] = '{1'b1, OFS_CAUSE_WDT, 32'h0300, 32'h8300, RESP_OKAY};
        rows[5] = '{1'b1, OFS_GEAR, 32'h2000, 32'h0, RESP_OKAY};
        rows[6] = '{1'b1, OFS_GEAR, 32'hC100, 32'hC100, RESP_OKAY};
        rows[7] = '{1'b1, OFS_TB_CLEAR, 32'hA5, 32'h0, RESP_OKAY};
        rows[8] = '{1'b1, 8'h20, 32'h1234, 32'h0, RESP_SLVERR};
        rows[9] = '{1'b1, OFS_DMA_HOLD, 32'h0F00, 32'h0F00, RESP_OKAY};
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        waits(0, 1'b1, n);
        foreach (rows[i]) begin
            if (rows[i].wr) wr_chk(rows[i].addr, rows[i].wdata, rows[i].resp);
            rd_chk(rows[i].addr, rows[i].rdata, rows[i].resp);
        end
        dma_want <= 1'b1;
        repeat (3) @(posedge clk_sys);
        `CHK(dma_req_out, 1'b0)
        wr_chk(OFS_DMA_HOLD, 32'h0, RESP_OKAY);
        repeat (3) @(posedge clk_sys);
        `CHK(dma_req_out, 1'b1)
        dma_want <= 1'b0;
        for (k = 0; k < 8; k++) begin
            wr_chk(OFS_GEAR, 32'((k % 4) << 14) | 32'((k / 4) << 8), RESP_OKAY);
            period(n);
            period(n);
            `CHK(n, ((k / 4) ? 4 : 3) << (k % 4))
        end
        wr_chk(OFS_STANDBY, 32'h005C, RESP_OKAY);
        count(40, a, b);
        `CHK(a, 0)
        `CHK(b > 5, 1'b1)
        `CHK(osc_run, 1'b1)
        wake_irq <= 1'b1;
        waits(1, 1'b1, n);
        wake_irq <= 1'b0;
        `CHK(n < 40, 1'b1)
        wr_chk(OFS_STANDBY, 32'h00FC, RESP_OKAY);
        count(40, a, b);
        `CHK(a + b, 0)
        `CHK(osc_run, 1'b0)
        `CHK(pin_float, 1'b1)
        wake_irq <= 1'b1;
        repeat (2) @(posedge clk_sys);
        wake_irq <= 1'b0;
        waits(1, 1'b1, n);
        `CHK(n >= 480 && n <= 640, 1'b1)
        `CHK(pin_float, 1'b0)
        wr_chk(OFS_GEAR, 32'h0, RESP_OKAY);
        wr_chk(OFS_STANDBY, 32'h0014, RESP_OKAY);
        d0 = dips;
        wr_chk(OFS_STANDBY, 32'h0004, RESP_OKAY);
        waits(0, 1'b1, n);
        repeat (8) @(posedge clk_sys);
        `CHK(dips, d0 + 1)
        rd_chk(OFS_CAUSE_WDT, 32'h0800, RESP_OKAY);
        rd_chk(OFS_STANDBY, 32'h0014, RESP_OKAY);
        rd_chk(OFS_GEAR, 32'hC100, RESP_OKAY);
        d0 = dips;
        pin_reset_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        pin_reset_n <= 1'b1;
        waits(0, 1'b1, n);
        `CHK(dips, d0 + 1)
        rd_chk(OFS_CAUSE_WDT, 32'h1000, RESP_OKAY);
        rd_chk(OFS_STANDBY, 32'h0014, RESP_OKAY);
        bus_hold <= 1'b0;
        // Clearing the timebase every eight cycles keeps the watchdog from ever reaching a carry.
        d0 = dips;
        for (k = 0; k < 10; k++) begin
            wr_chk(OFS_TB_CLEAR, 32'hA5, RESP_OKAY);
            wr_chk(OFS_TB_CLEAR, 32'h5A, RESP_OKAY);
        end
        `CHK(dips, d0)
        wr_chk(OFS_WD_SERVICE, 32'hA5, RESP_OKAY);
        wr_chk(OFS_WD_SERVICE, 32'h5A, RESP_OKAY);
        waits(0, 1'b0, n);
        bus_hold <= 1'b1;
        `CHK(n >= 28 && n <= 70, 1'b1)
        waits(0, 1'b1, n);
        rd_chk(OFS_CAUSE_WDT, 32'h2000, RESP_OKAY);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        waits(0, 1'b1, n);
        rd_chk(OFS_CAUSE_WDT, 32'h8000, RESP_OKAY);
        rd_chk(OFS_STANDBY, 32'h001C, RESP_OKAY);
        results();
    end
endmodule
